// ### ssg_sync_gen.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Stereo shutter sync generator
// ----------------------------------------------------------------------
module ssg_sync_gen #(
    parameter int CNT_W = ssg_pkg::CNT_W,
    parameter int LEAD_CYC = ssg_pkg::LEAD_CYC,
    parameter int BASE_CYC = ssg_pkg::BASE_CYC,
    parameter int DELTA_CYC = ssg_pkg::DELTA_CYC,
    parameter int WIDTH_CYC = ssg_pkg::WIDTH_CYC
)(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic stereo_active,
    input wire logic light_mode,
    input wire logic ir_mode,
    input wire logic frame_start,
    input wire logic frame_left_next,
    output logic eye_select,
    output logic eye_sync_pin,
    output logic light_pulse,
    output logic illum_allow,
    output logic [1:0] pulse_color
);
    // ------------------------------------------------------------------
    // Cycle constants at counter width
    // ------------------------------------------------------------------
    localparam logic [CNT_W-1:0] LEAD_C = CNT_W'(LEAD_CYC);
    localparam logic [CNT_W-1:0] BASE_C = CNT_W'(BASE_CYC);
    localparam logic [CNT_W-1:0] LONG_C = CNT_W'(BASE_CYC + DELTA_CYC);
    localparam logic [CNT_W-1:0] CNT_MAX = '1;

    // True when cnt sits exactly back cycles before the predicted vsync
    function automatic logic at_point(input logic [CNT_W-1:0] cnt,
                                      input logic [CNT_W-1:0] period,
                                      input logic [CNT_W-1:0] back);
        at_point = (period > back) && (cnt == period - back);
    endfunction

    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic [CNT_W-1:0] period_reg;
    logic [CNT_W-1:0] period_next;
    logic per_valid_reg;
    logic per_valid_next;
    logic long_sel_reg;
    logic long_sel_next;
    logic armed_reg;
    logic armed_next;
    logic pulsed_reg;
    logic pulsed_next;
    logic closed_reg;
    logic closed_next;
    logic eye_reg;
    logic eye_next;
    logic pin_reg;
    logic pin_next;
    logic illum_reg;
    logic illum_next;
    logic [1:0] color_reg;
    logic [1:0] color_next;
    logic [CNT_W-1:0] off_c;
    logic toggle_hit;
    logic pulse_hit;
    logic pulse_go;

    ssg_tmr_if #(.W(ssg_pkg::TMR_W)) tmr ();

    // ------------------------------------------------------------------
    // Frame timing reference
    // ------------------------------------------------------------------
    // Cycle count restarts at every vsync; the last full count predicts
    // when the next vsync lands, which is how we look ahead by 1 ms
    always_comb
    begin
        cnt_next = (cnt_reg == CNT_MAX) ? cnt_reg : cnt_reg + CNT_W'(1);
        period_next = period_reg;
        per_valid_next = per_valid_reg;
        long_sel_next = long_sel_reg;
        armed_next = armed_reg;
        // A period counted from reset or from a stereo gap is not a frame,
        // so it is trusted only between two frame starts seen in stereo
        if (frame_start)
        begin
            cnt_next = '0;
            period_next = cnt_reg + CNT_W'(1);
            per_valid_next = armed_reg && (cnt_reg != CNT_MAX);
            long_sel_next = !long_sel_reg;
            armed_next = 1'b1;
        end
        if (!stereo_active)
        begin
            per_valid_next = 1'b0;
            armed_next = 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            cnt_reg <= '0;
            period_reg <= '0;
            per_valid_reg <= 1'b0;
            long_sel_reg <= 1'b0;
            armed_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            cnt_reg <= cnt_next;
            period_reg <= period_next;
            per_valid_reg <= per_valid_next;
            long_sel_reg <= long_sel_next;
            armed_reg <= armed_next;
        end
    end

    // ------------------------------------------------------------------
    // Event points within the frame
    // ------------------------------------------------------------------
    // Offset alternates frame by frame; long offset is always B plus D
    assign off_c = long_sel_reg ? LONG_C : BASE_C;
    assign toggle_hit = per_valid_reg && at_point(cnt_reg, period_reg, LEAD_C);
    assign pulse_hit = per_valid_reg && at_point(cnt_reg, period_reg, off_c);
    assign pulse_go = pulse_hit && light_mode && !pulsed_reg;

    // ------------------------------------------------------------------
    // Eye select, pin, closed window, light gating
    // ------------------------------------------------------------------
    // Eye select follows the eye of the coming frame, changed at the lead
    // point; outside stereo it rests low so the glasses stay idle
    always_comb
    begin
        eye_next = eye_reg;
        closed_next = closed_reg;
        pulsed_next = pulsed_reg;
        if (toggle_hit)
        begin
            eye_next = frame_left_next;
            closed_next = 1'b1;
        end
        if (frame_start)
        begin
            closed_next = 1'b0;
            pulsed_next = 1'b0;
        end
        else if (pulse_go)
        begin
            pulsed_next = 1'b1;
        end
        if (!stereo_active)
        begin
            eye_next = ssg_pkg::EYE_RST;
            closed_next = 1'b0;
        end
        pin_next = ir_mode && eye_next;
        // Both shutters are closed in the lead window; in light mode, light only for pulse
        illum_next = !(stereo_active && light_mode) || !closed_next
                     || pulse_go || tmr.busy;
        color_next = ssg_pkg::PULSE_COLOR;
    end

    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            eye_reg <= ssg_pkg::EYE_RST;
            closed_reg <= 1'b0;
            pulsed_reg <= 1'b0;
            pin_reg <= 1'b0;
            illum_reg <= ssg_pkg::ILLUM_RST;
            color_reg <= ssg_pkg::PULSE_COLOR;
        end
        else if (clk_en)
        begin
            eye_reg <= eye_next;
            closed_reg <= closed_next;
            pulsed_reg <= pulsed_next;
            pin_reg <= pin_next;
            illum_reg <= illum_next;
            color_reg <= color_next;
        end
    end

    // ------------------------------------------------------------------
    // Light pulse timer
    // ------------------------------------------------------------------
    // Width limited to the timer width; A of 20 to 32 us fits easily
    assign tmr.load = pulse_go;
    assign tmr.len = ssg_pkg::TMR_W'(WIDTH_CYC);

    ssg_pulse_timer #(.W(ssg_pkg::TMR_W)) u_tmr (
        .clk(clk),
        .reset_n(reset_n),
        .clk_en(clk_en),
        .t(tmr.tmr)
    );

    assign eye_select = eye_reg;
    assign eye_sync_pin = pin_reg;
    assign light_pulse = tmr.busy;
    assign illum_allow = illum_reg;
    assign pulse_color = color_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [ssg_pkg::TMR_W-1:0] pw_cnt;
    logic [1:0] pulses_in_frame;

    // Helper counters: pulse width in enabled cycles and pulses per frame
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            pw_cnt <= '0;
            pulses_in_frame <= '0;
        end
        else if (clk_en)
        begin
            pw_cnt <= light_pulse ? pw_cnt + ssg_pkg::TMR_W'(1) : '0;
            if (frame_start)
            begin
                pulses_in_frame <= '0;
            end
            else if (pulse_go && pulses_in_frame != 2'h3)
            begin
                pulses_in_frame <= pulses_in_frame + 2'h1;
            end
        end
    end

    sequence s_pulse_go;
        clk_en && pulse_go && stereo_active;
    endsequence

    sequence s_pulse_on;
        light_pulse && illum_allow;
    endsequence

    eye_left_high_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && toggle_hit && stereo_active |=> eye_select == $past(frame_left_next))
        else $error("eye select does not show the coming eye");

    eye_lead_a: assert property (@(posedge clk) disable iff (!reset_n)
        $changed(eye_select) && $past(stereo_active) |->
        $past(toggle_hit) && $past(clk_en))
        else $error("eye select changed away from the lead point");

    idle_low_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !stereo_active |=> !eye_select)
        else $error("eye select not low outside stereo");

    pin_follow_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && ir_mode && stereo_active |=> eye_sync_pin == eye_select)
        else $error("sync pin does not follow eye select");

    one_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
        pulses_in_frame <= 2'h1)
        else $error("more than one light pulse in a frame");

    pulse_start_a: assert property (@(posedge clk) disable iff (!reset_n)
        s_pulse_go |=> s_pulse_on)
        else $error("light pulse did not start at its offset");

    dark_window_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && stereo_active && light_mode && closed_reg && !frame_start
        && !toggle_hit && !pulse_go && !light_pulse |=> !illum_allow)
        else $error("light on while both shutters closed");

    offset_alt_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && frame_start |=> long_sel_reg != $past(long_sel_reg))
        else $error("pulse offset did not alternate");

    long_sum_a: assert property (@(posedge clk) disable iff (!reset_n)
        long_sel_reg |-> off_c == BASE_C + CNT_W'(DELTA_CYC))
        else $error("long offset is not base plus delta");

    pulse_width_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(light_pulse) |-> pw_cnt == ssg_pkg::TMR_W'(WIDTH_CYC))
        else $error("light pulse width wrong");

    delta_gap_a: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |-> LONG_C - BASE_C == CNT_W'(DELTA_CYC))
        else $error("delta offset wrong");

    color_red_a: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> pulse_color == 2'h0)
        else $error("pulse colour not red");

    frame_restart_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && frame_start |=> cnt_reg == '0)
        else $error("frame counter not restarted");

    period_arm_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && frame_start && !armed_reg |=> !per_valid_reg)
        else $error("period trusted before two frame starts");

    pin_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && !ir_mode |=> !eye_sync_pin)
        else $error("sync pin driven outside infrared mode");

    closed_dark_a: assert property (@(posedge clk) disable iff (!reset_n)
        clk_en && stereo_active && light_mode && toggle_hit && !frame_start
        && !pulse_go && !light_pulse |=> !illum_allow)
        else $error("light still on as shutters close");

endmodule
`default_nettype wire

// ### ssg_pkg.sv
// Overview of operation
// - Stereo input active: align shutter sync to frames
// - Drive eye sync pin for infrared transmitter
// - Eye select high for left, low right
// - Eye select changes 1 ms before vsync
// - Light mode: one pulse per frame once the period is trusted, none before
// - Tell illumination driver when to switch on
// - Shutters closed in light mode: light off except pulse
// - Offset alternates B and B+D, B over 500us
// - Long offset C equals B plus D
// - Pulse width A within 20 to 32us
// - Delta D within 128 to 163us
// - Pulse colour red, never blue
package ssg_pkg;

    // ------------------------------------------------------------------
    // Clock and timing figures
    // ------------------------------------------------------------------
    localparam int CLK_KHZ = 125000;
    localparam int LEAD_US = 1000;      // Eye change lead before vsync
    localparam int BASE_US = 520;       // Base offset B, above 500 us
    localparam int DELTA_NS = 132000;   // Delta D, nominal at 120 Hz
    localparam int WIDTH_NS = 26000;    // Pulse width A, nominal at 120 Hz
    localparam int LEAD_CYC = (LEAD_US * CLK_KHZ + 999) / 1000;
    localparam int BASE_CYC = (BASE_US * CLK_KHZ + 999) / 1000;
    localparam int DELTA_CYC = (DELTA_NS / 1000) * (CLK_KHZ / 1000);
    localparam int WIDTH_CYC = (WIDTH_NS / 1000) * (CLK_KHZ / 1000);

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int CNT_W = 24;
    localparam int TMR_W = 16;
    localparam logic EYE_RST = 1'b0;
    localparam logic ILLUM_RST = 1'b1;

    // ------------------------------------------------------------------
    // Pulse colour code for the illumination driver
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        SSG_COL_RED = 2'h0,
        SSG_COL_GREEN = 2'h1,
        SSG_COL_BLUE = 2'h2
    } ssg_color_t;
    localparam ssg_color_t PULSE_COLOR = SSG_COL_RED;

endpackage

// ### ssg_tmr_if.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Pulse timer control carrier
// ----------------------------------------------------------------------
interface ssg_tmr_if #(
    parameter int W = ssg_pkg::TMR_W
);
    logic load;
    logic [W-1:0] len;
    logic busy;
    modport ctl (output load, output len, input busy);
    modport tmr (input load, input len, output busy);
endinterface
`default_nettype wire

// ### ssg_pulse_timer.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// One-shot pulse timer: busy stays high for exactly len enabled cycles
// ----------------------------------------------------------------------
module ssg_pulse_timer #(
    parameter int W = ssg_pkg::TMR_W
)(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    ssg_tmr_if.tmr t
);
    logic [W-1:0] cnt_reg;
    logic [W-1:0] cnt_next;
    logic busy_reg;
    logic busy_next;

    // Load wins over a running count so a retrigger restarts cleanly
    always_comb
    begin
        cnt_next = cnt_reg;
        if (t.load)
        begin
            cnt_next = t.len;
        end
        else if (cnt_reg != '0)
        begin
            cnt_next = cnt_reg - W'(1);
        end
        busy_next = (cnt_next != '0);
    end

    // Registered busy keeps the light command glitch free
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            cnt_reg <= cnt_next;
            busy_reg <= busy_next;
        end
    end

    assign t.busy = busy_reg;

endmodule
`default_nettype wire

// ### ssg_illum_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------------
// Illumination driver stand-in: measures each sync light pulse
// ----------------------------------------------------------------------
module ssg_illum_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic frame_start,
    input wire logic light_pulse,
    output logic [7:0] frame_pulses,
    output logic [7:0] last_width,
    output logic pulse_done
);
    logic [7:0] run_w;
    logic [7:0] cnt_p;
    logic lp_d;
    // Source is lit only while the command stands; width in enabled cycles
    always @(posedge clk)
    begin
        pulse_done <= 1'b0;
        if (!reset_n) // Reset acts on a stalled cycle too
        begin
            run_w <= 8'h00;
            cnt_p <= 8'h00;
            lp_d <= 1'b0;
            frame_pulses <= 8'h00;
            last_width <= 8'h00;
        end
        else if (clk_en)
        begin
            lp_d <= light_pulse;
            if (light_pulse)
                run_w <= run_w + 8'h01;
            if (light_pulse && !lp_d)
                cnt_p <= cnt_p + 8'h01;
            if (lp_d && !light_pulse)
            begin
                last_width <= run_w;
                run_w <= 8'h00;
                pulse_done <= 1'b1;
            end
            // Pulses are tallied per frame, so a doubled pulse shows up
            if (frame_start)
            begin
                frame_pulses <= cnt_p;
                cnt_p <= 8'h00;
            end
        end
    end
endmodule
`default_nettype wire

// ### tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ------------------------------------------------------------------
    // Scaled timing and bench state
    // ------------------------------------------------------------------
    localparam int LEAD = 40;
    localparam int BASE = 20;
    localparam int DELTA = 5;
    localparam int WIDTH = 4;
    typedef struct {
        int cnt, per, lp, pf, pfl;
        bit seen, lng, hit, closed, eye, pin, ill, fs;
    } ssg_mdl_t;
    ssg_mdl_t m = '{ill: 1, default: 0};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic clk_en = 1'b1;
    logic stereo_active = 1'b1;
    logic light_mode = 1'b1;
    logic ir_mode = 1'b1;
    logic frame_start = 1'b0;
    logic frame_left_next = 1'b0;
    logic eye_select, eye_sync_pin, light_pulse, illum_allow;
    logic [1:0] pulse_color;
    logic [7:0] frame_pulses, last_width;
    logic pulse_done;
    logic [31:0] rnd = 32'h00015C89;
    int failures = 0;
    int checked = 0;
    int cyc = 0;
    int fr = 0;
    int gc = 0;
    int per_set = 100;
    int off;
    bit lp_now, load, en_n, fs_n;

    always #4 clk = ~clk;

    ssg_sync_gen #(.LEAD_CYC(LEAD), .BASE_CYC(BASE), .DELTA_CYC(DELTA),
        .WIDTH_CYC(WIDTH)) dut (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .stereo_active(stereo_active), .light_mode(light_mode), .ir_mode(ir_mode),
        .frame_start(frame_start), .frame_left_next(frame_left_next),
        .eye_select(eye_select), .eye_sync_pin(eye_sync_pin),
        .light_pulse(light_pulse), .illum_allow(illum_allow),
        .pulse_color(pulse_color));
    ssg_illum_model pm (.clk(clk), .reset_n(reset_n), .clk_en(clk_en),
        .frame_start(frame_start), .light_pulse(light_pulse),
        .frame_pulses(frame_pulses), .last_width(last_width),
        .pulse_done(pulse_done));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    task automatic chk(input string what, input logic [7:0] got,
        input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t %s got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic stop_test();
        if (failures == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Reference model, then next stimulus; frozen while clk_en is low
    // ------------------------------------------------------------------
    always @(posedge clk)
    begin
        m.fs = 0;
        load = 0;
        if (!reset_n) // Reset acts on a stalled cycle too, as in the design
        begin
            m = '{ill: 1, default: 0};
            gc = 0;
        end
        else if (clk_en)
        begin
            lp_now = m.lp > 0;
            if (m.lp > 0)
                m.lp--;
            off = m.lng ? BASE + DELTA : BASE;
            // Counts restart at every frame start; period learned each frame
            if (frame_start)
            begin
                if (m.seen)
                    m.per = m.cnt + 1;
                m.seen = 1;
                m.lng = !m.lng;
                m.hit = 0;
                m.closed = 0;
                m.cnt = 0;
                m.pfl = m.pf;
                m.pf = 0;
                m.fs = 1;
            end
            else
            begin
                if (m.per > 0 && m.cnt == m.per - LEAD)
                begin
                    m.eye = frame_left_next;
                    m.closed = 1;
                end
                if (m.per > 0 && light_mode && stereo_active && !m.hit
                    && m.cnt == m.per - off)
                begin
                    m.lp = WIDTH;
                    m.hit = 1;
                    m.pf++;
                    load = 1;
                end
                m.cnt++;
            end
            if (!stereo_active)
            begin
                m.per = 0;
                m.seen = 0;
                m.eye = 0;
                m.closed = 0;
            end
            m.pin = ir_mode && m.eye;
            m.ill = !(light_mode && stereo_active && m.closed) || load || lp_now;
            gc = frame_start ? 0 : gc + 1;
        end
        // Random stalls, but a frame start is only offered on a live cycle
        rnd = lfsr(rnd);
        en_n = (rnd[2:0] != 3'h0) || !reset_n;
        fs_n = en_n && reset_n && (gc == per_set - 1);
        clk_en <= en_n;
        frame_start <= fs_n;
        if (fs_n)
        begin
            fr++;
            frame_left_next <= rnd[5];
            ir_mode <= !(fr >= 6 && fr < 9);
            light_mode <= !(fr >= 9 && fr < 12);
            stereo_active <= !(fr >= 12 && fr < 14);
            per_set = (fr >= 14 && fr < 20) ? 130 : 100;
        end
    end

    // ------------------------------------------------------------------
    // Compare every cycle where outputs have settled
    // ------------------------------------------------------------------
    always @(negedge clk)
    begin
        if (cyc > 0)
        begin
            chk("eye", 8'(eye_select), 8'(m.eye));
            chk("pin", 8'(eye_sync_pin), 8'(m.pin));
            chk("pulse", 8'(light_pulse), 8'(m.lp > 0));
            chk("allow", 8'(illum_allow), 8'(m.ill));
            chk("colour", 8'(pulse_color), 8'h00);
            if (pulse_done)
                chk("width", last_width, 8'(WIDTH));
            if (m.fs)
                chk("count", frame_pulses, 8'(m.pfl));
        end
    end

    // Hang guard: the run needs about 3300 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc >= 20000)
        begin
            failures++;
            stop_test();
        end
    end

    // Main sequence: reset, run frames, reset again mid-run
    initial
    begin
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        wait (fr == 20);
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (2) @(posedge clk);
        reset_n <= 1'b1;
        wait (fr == 27);
        stop_test();
    end
endmodule
`default_nettype wire
